/* File: inc/tcs_pkg.sv */
package tcs_pkg;
  // Register byte addresses on the AXI4-Lite port
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h0c;
  localparam logic [7:0] ADDR_PTR = 8'h10;
  localparam logic [7:0] ADDR_LIMIT = 8'h14;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Control and status fields
  localparam int unsigned CTRL_HOST_ABORT = 0;
  localparam int unsigned CTRL_MAC_RESET = 1;
  localparam logic CTRL_HOST_ABORT_RST = 1'h1;
  localparam int unsigned STAT_ACTIVE = 0;
  localparam int unsigned STAT_DRAIN = 1;
  localparam int unsigned STAT_IN_FRAME = 2;
  localparam int unsigned STAT_RS_LSB = 4;
  // Interrupt status and mask layout
  localparam int unsigned IRQ_W = 4;
  localparam int unsigned IRQ_CNF = 0;
  localparam int unsigned IRQ_EXC = 1;
  localparam int unsigned IRQ_PSP = 2;
  localparam int unsigned IRQ_SPACE = 3;
  // Request status codes
  localparam logic [3:0] RS_NONE = 4'h0;
  localparam logic [3:0] RS_OK = 4'h6;
  localparam logic [3:0] RS_UNDERRUN = 4'h8;
  localparam logic [3:0] RS_HOST_ABORT = 4'h9;
  localparam logic [3:0] RS_BAD_RINGOP = 4'ha;
  localparam logic [3:0] RS_DEV_ABORT = 4'hb;
  localparam logic [3:0] RS_TIMEOUT = 4'hc;
  localparam logic [3:0] RS_MAC_RESET = 4'hd;
  localparam logic [3:0] RS_CONSIST = 4'he;
  localparam logic [3:0] RS_FATAL = 4'hf;
  // Request classes
  localparam logic [1:0] CLS_IMMEDIATE = 2'h3;
  // Descriptor first/last tag, bit 1 is first, bit 0 is last
  localparam int unsigned TAG_FIRST = 1;
  localparam int unsigned TAG_LAST = 0;
  // Pool space pointer layout
  localparam int unsigned LOC_W = 28;
  localparam int unsigned PAGE_BITS = 12;
  localparam int unsigned FL_LSB = 30;
  localparam logic [LOC_W-PAGE_BITS-1:0] PAGE_ONE = 16'h0001;
  localparam logic [PAGE_BITS-1:0] PAGE_ZERO = 12'h000;
  localparam logic [LOC_W-1:0] PTR_STEP = 28'h0000004;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ACTIVE = 2'b01,
    ST_DRAIN = 2'b10
  } tcs_req_state_t;

  typedef struct packed {
    logic awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [ADDR_W-1:0] araddr;
    logic rready;
  } tcs_axi_m2s_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } tcs_axi_s2m_t;

  // Events from the ring engine transmit logic, one-cycle pulses unless noted
  typedef struct packed {
    logic req_start;
    logic [1:0] req_class;
    logic ring_op;
    logic tht_en;
    logic output_data_unit_descriptor_valid;
    logic [1:0] output_data_unit_descriptor_tag;
    logic frame_end;
    logic req_end;
    logic cnf_space_low;
    logic parity_err;
    logic fc_fail;
    logic mac_frame_in_data;
    logic other_beacon_in_beacon;
    logic claim_lost_in_claim;
    logic trt_expired;
    logic tht_expired;
    logic illegal_state;
    logic tx_internal_err;
    logic bus_err;
    logic underrun;
  } tcs_tx_evt_t;

  typedef struct packed {
    logic [31:0] word0;
    logic [31:0] word1;
  } tcs_psp_t;

  typedef struct packed {
    tcs_req_state_t st;
    logic tht_en;
    logic in_frame;
    logic host_abort_bit;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic [3:0] last_rs;
    logic cnf_valid;
    logic [3:0] cnf_rs;
    logic tx_abort;
    logic req_abort;
    logic rel_tok;
    logic [LOC_W-1:0] ptr;
    logic [LOC_W-1:0] limit;
    logic aw_full;
    logic [ADDR_W-1:0] awaddr;
    logic w_full;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } tcs_state_t;
endpackage

/* File: core/tcs_core.sv */
// The register addresses and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/100ps
module tcs_core
  import tcs_pkg::*;
(
  input wire logic CLOCK_I, // 100 MHz clock
  input wire logic RST_B_I, // Async reset, active low
  input wire tcs_axi_m2s_t AXI_I, // AXI4-Lite master side
  output tcs_axi_s2m_t AXI_O, // AXI4-Lite slave side
  input wire tcs_tx_evt_t EVT_I, // Transmit logic events
  input wire logic PSP_VALID_I, // Pool space pointer read
  input wire tcs_psp_t PSP_I, // Pool space pointer words
  input wire logic IND_WR_I, // One word written to indicate space
  output logic CNF_VALID_O, // Confirmation strobe
  output logic [3:0] CNF_RS_O, // Request status code
  output logic TX_ABORT_O, // Transmit abort indication
  output logic REQ_ABORT_O, // Request ended abnormally
  output logic TOKEN_RELEASE_O, // Release token after frame
  output logic [LOC_W-1:0] IND_PTR_O, // Indicate write pointer
  output logic [LOC_W-1:0] IND_LIMIT_O, // End of indicate space
  output logic IND_SPACE_END_O, // Indicate space used up
  output logic IRQ_O // Level interrupt
);
  tcs_state_t s_r;
  tcs_state_t s_nxt;
  logic [31:0] wmask;

  // Byte lanes of the write strobe, one mask byte per strobe bit
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_mask
      assign wmask[gi*8 +: 8] = {8{s_r.wstrb[gi]}};
    end
  endgenerate

  always_comb begin
    logic wr_fire;
    logic host_clr;
    logic sw_reset;
    logic end_now;
    logic [3:0] code;
    logic [31:0] wd;
    logic [31:0] rd;
    logic [IRQ_W-1:0] irq_set;
    wr_fire = 1'b0;
    host_clr = 1'b0;
    sw_reset = 1'b0;
    end_now = 1'b0;
    code = RS_NONE;
    wd = 32'h0;
    rd = 32'h0;
    irq_set = '0;
    s_nxt = s_r;
    s_nxt.cnf_valid = 1'b0;
    s_nxt.tx_abort = 1'b0;
    s_nxt.req_abort = 1'b0;
    s_nxt.rel_tok = 1'b0;

    // Write channel: address and data taken in either order
    if (AXI_I.awvalid && !s_r.aw_full && !s_r.bvalid) begin
      s_nxt.aw_full = 1'b1;
      s_nxt.awaddr = AXI_I.awaddr;
    end
    if (AXI_I.wvalid && !s_r.w_full && !s_r.bvalid) begin
      s_nxt.w_full = 1'b1;
      s_nxt.wdata = AXI_I.wdata;
      s_nxt.wstrb = AXI_I.wstrb;
    end
    if (s_r.bvalid && AXI_I.bready) begin
      s_nxt.bvalid = 1'b0;
    end
    wr_fire = s_r.aw_full && s_r.w_full && !s_r.bvalid;
    if (wr_fire) begin
      s_nxt.aw_full = 1'b0;
      s_nxt.w_full = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = RESP_OKAY;
      wd = s_r.wdata & wmask;
      case (s_r.awaddr)
        ADDR_CTRL: begin
          if (s_r.wstrb[0]) begin
            s_nxt.host_abort_bit = s_r.wdata[CTRL_HOST_ABORT];
            host_clr = s_r.host_abort_bit && !s_r.wdata[CTRL_HOST_ABORT];
            sw_reset = s_r.wdata[CTRL_MAC_RESET];
          end
        end
        ADDR_IRQ_STAT: begin
          // Write one to clear; events of this cycle are merged back below
          s_nxt.irq_stat = s_r.irq_stat & ~wd[IRQ_W-1:0];
        end
        ADDR_IRQ_MASK: begin
          s_nxt.irq_mask = (s_r.irq_mask & ~wmask[IRQ_W-1:0]) | wd[IRQ_W-1:0];
        end
        ADDR_STAT, ADDR_PTR, ADDR_LIMIT: begin
          // Read-only words accept the write and keep their value
          s_nxt.bresp = RESP_OKAY;
        end
        default: begin
          s_nxt.bresp = RESP_SLVERR;
        end
      endcase
    end

    // Read channel: one read in flight, answer the cycle after address
    if (s_r.rvalid && AXI_I.rready) begin
      s_nxt.rvalid = 1'b0;
    end
    if (AXI_I.arvalid && !s_r.rvalid) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp = RESP_OKAY;
      case (AXI_I.araddr)
        ADDR_CTRL: begin
          // The reset request bit is a pulse and always reads as zero
          rd[CTRL_HOST_ABORT] = s_r.host_abort_bit;
        end
        ADDR_STAT: begin
          rd[STAT_ACTIVE] = (s_r.st != ST_IDLE);
          rd[STAT_DRAIN] = (s_r.st == ST_DRAIN);
          rd[STAT_IN_FRAME] = s_r.in_frame;
          rd[STAT_RS_LSB +: 4] = s_r.last_rs;
        end
        ADDR_IRQ_STAT: begin
          rd[IRQ_W-1:0] = s_r.irq_stat;
        end
        ADDR_IRQ_MASK: begin
          rd[IRQ_W-1:0] = s_r.irq_mask;
        end
        ADDR_PTR: begin
          rd[LOC_W-1:0] = s_r.ptr;
        end
        ADDR_LIMIT: begin
          rd[LOC_W-1:0] = s_r.limit;
        end
        default: begin
          // Unmapped words answer with an error and zero data
          s_nxt.rresp = RESP_SLVERR;
        end
      endcase
      s_nxt.rdata = rd;
    end

    // Request sequencing; the most severe cause wins when several coincide
    case (s_r.st)
      ST_IDLE: begin
        if (EVT_I.req_start) begin
          if ((EVT_I.req_class == CLS_IMMEDIATE) == EVT_I.ring_op) begin
            end_now = 1'b1;
            code = RS_BAD_RINGOP;
          end else begin
            s_nxt.st = ST_ACTIVE;
            // Holding timer choice is fixed for the whole request
            s_nxt.tht_en = EVT_I.tht_en;
            s_nxt.in_frame = 1'b0;
          end
        end
      end
      ST_ACTIVE, ST_DRAIN: begin
        if (sw_reset || EVT_I.illegal_state) begin
          end_now = 1'b1;
          code = RS_MAC_RESET;
        end else if (EVT_I.tx_internal_err || EVT_I.bus_err) begin
          end_now = 1'b1;
          code = RS_FATAL;
        end else if (EVT_I.output_data_unit_descriptor_valid && EVT_I.output_data_unit_descriptor_tag[TAG_FIRST] && s_r.in_frame) begin
          end_now = 1'b1;
          code = RS_CONSIST;
        end else if (EVT_I.parity_err || EVT_I.fc_fail || EVT_I.mac_frame_in_data ||
                     EVT_I.other_beacon_in_beacon || EVT_I.claim_lost_in_claim) begin
          end_now = 1'b1;
          code = RS_DEV_ABORT;
          s_nxt.tx_abort = 1'b1;
        end else if (EVT_I.underrun) begin
          end_now = 1'b1;
          code = RS_UNDERRUN;
        end else if (!s_r.tht_en && EVT_I.trt_expired) begin
          end_now = 1'b1;
          code = RS_TIMEOUT;
        end else if (host_clr || EVT_I.cnf_space_low) begin
          end_now = 1'b1;
          code = RS_HOST_ABORT;
        end else if (s_r.st == ST_DRAIN && EVT_I.frame_end) begin
          s_nxt.rel_tok = 1'b1;
          end_now = 1'b1;
          code = RS_OK;
        end else if (s_r.st == ST_ACTIVE && EVT_I.req_end) begin
          end_now = 1'b1;
          code = RS_OK;
        end else begin
          if (EVT_I.output_data_unit_descriptor_valid) begin
            // Middle parts leave the frame state alone
            if (EVT_I.output_data_unit_descriptor_tag[TAG_LAST]) begin
              s_nxt.in_frame = 1'b0;
            end else if (EVT_I.output_data_unit_descriptor_tag[TAG_FIRST]) begin
              s_nxt.in_frame = 1'b1;
            end
          end
          // holding timer expiry does not abort
          if (s_r.st == ST_ACTIVE && s_r.tht_en && EVT_I.tht_expired) begin
            s_nxt.st = ST_DRAIN;
          end
        end
      end
      default: begin
        // Unused state code: fall back to idle without a confirmation
        s_nxt.st = ST_IDLE;
      end
    endcase

    if (end_now) begin
      s_nxt.st = ST_IDLE;
      s_nxt.in_frame = 1'b0;
      s_nxt.cnf_valid = 1'b1;
      s_nxt.cnf_rs = code;
      s_nxt.last_rs = code;
      s_nxt.req_abort = (code != RS_OK);
      irq_set[IRQ_CNF] = 1'b1;
      irq_set[IRQ_EXC] = (code != RS_OK);
    end

    // Pool space pointer; the byte count in word 0 is deliberately unused
    if (PSP_VALID_I) begin
      s_nxt.ptr = PSP_I.word1[LOC_W-1:0];
      s_nxt.limit = {PSP_I.word1[LOC_W-1:PAGE_BITS] + PAGE_ONE, PAGE_ZERO};
      irq_set[IRQ_PSP] = 1'b1;
    end else if (IND_WR_I && s_r.ptr != s_r.limit) begin
      // Writes past the end are dropped; the pointer parks at the limit
      s_nxt.ptr = s_r.ptr + PTR_STEP;
      irq_set[IRQ_SPACE] = (s_r.ptr + PTR_STEP == s_r.limit);
    end

    // Sticky events: a set in the clearing cycle survives
    s_nxt.irq_stat = s_nxt.irq_stat | irq_set;
  end

  always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      s_r <= '0;
      s_r.st <= ST_IDLE;
      // Starts set, so only a deliberate clear aborts a request
      s_r.host_abort_bit <= CTRL_HOST_ABORT_RST;
      s_r.cnf_rs <= RS_NONE;
      s_r.last_rs <= RS_NONE;
    end else begin
      s_r <= s_nxt;
    end
  end

  always_comb begin
    // Ready stays low while a response waits: one write in flight
    AXI_O.awready = !s_r.aw_full && !s_r.bvalid;
    AXI_O.wready = !s_r.w_full && !s_r.bvalid;
    AXI_O.bvalid = s_r.bvalid;
    AXI_O.bresp = s_r.bresp;
    AXI_O.arready = !s_r.rvalid;
    AXI_O.rvalid = s_r.rvalid;
    AXI_O.rdata = s_r.rdata;
    AXI_O.rresp = s_r.rresp;
  end

  assign CNF_VALID_O = s_r.cnf_valid;
  assign CNF_RS_O = s_r.cnf_rs;
  assign TX_ABORT_O = s_r.tx_abort;
  assign REQ_ABORT_O = s_r.req_abort;
  assign TOKEN_RELEASE_O = s_r.rel_tok;
  assign IND_PTR_O = s_r.ptr;
  assign IND_LIMIT_O = s_r.limit;
  assign IND_SPACE_END_O = (s_r.ptr == s_r.limit);
  // Level output; clears as soon as software acknowledges the last bit
  assign IRQ_O = |(s_r.irq_stat & s_r.irq_mask);
endmodule

/* File: tb/tcs_monitor.sv */
`timescale 1ns/100ps
module tcs_monitor
  import tcs_pkg::*;
(
  input wire logic CLOCK_I, // Clock
  input wire logic RST_B_I, // Reset, active low
  input wire logic PSP_VALID_I, // Pointer load
  input wire tcs_psp_t PSP_I, // Pointer words
  input wire logic IND_WR_I, // Space write
  input wire logic CNF_VALID_O, // Confirmation
  input wire logic [3:0] CNF_RS_O, // Status code
  input wire logic TX_ABORT_O, // Abort indication
  input wire logic REQ_ABORT_O, // Abnormal end
  input wire logic TOKEN_RELEASE_O, // Token release
  input wire logic [LOC_W-1:0] IND_PTR_O, // Write pointer
  input wire logic [LOC_W-1:0] IND_LIMIT_O, // Space end
  input wire logic IND_SPACE_END_O // Space used up
);
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!RST_B_I);
  chk_abort_code:
  assert property (TX_ABORT_O |-> CNF_VALID_O && CNF_RS_O == RS_DEV_ABORT)
    else $error("abort indication without device abort code");
  chk_abnormal_end:
  assert property (CNF_VALID_O |-> REQ_ABORT_O == (CNF_RS_O != RS_OK))
    else $error("abnormal end flag disagrees with code");
  chk_token_release:
  assert property (TOKEN_RELEASE_O |-> CNF_VALID_O && CNF_RS_O == RS_OK)
    else $error("token release without good completion");
  chk_ptr_load:
  assert property (PSP_VALID_I |=> IND_PTR_O == $past(PSP_I.word1[LOC_W-1:0]))
    else $error("pointer not loaded from location");
  chk_limit_page:
  assert property (PSP_VALID_I |=>
    IND_LIMIT_O == {$past(PSP_I.word1[27:12]) + PAGE_ONE, PAGE_ZERO})
    else $error("space end not at next page boundary");
  chk_ptr_park:
  assert property (IND_WR_I && IND_SPACE_END_O && !PSP_VALID_I |=> $stable(IND_PTR_O))
    else $error("pointer stepped past space end");
  chk_ptr_step:
  assert property (IND_WR_I && !IND_SPACE_END_O && !PSP_VALID_I |=>
    IND_PTR_O == $past(IND_PTR_O) + PTR_STEP)
    else $error("pointer did not step one word");
  chk_code_hold:
  assert property (!CNF_VALID_O |-> $stable(CNF_RS_O))
    else $error("status code changed without confirmation");
  cover property (TX_ABORT_O);
  cover property (TOKEN_RELEASE_O);
  cover property ($rose(IND_SPACE_END_O));
endmodule

/* File: tb/tcs_host_mem.sv */
`timescale 1ns/100ps
module tcs_host_mem
  import tcs_pkg::*;
(
  input wire logic CLOCK_I, // Clock
  input wire logic RST_B_I, // Reset, active low
  input wire logic GO_I, // Fetch one descriptor
  input wire logic [1:0] LAT_I, // Extra wait cycles
  input wire logic [LOC_W-1:0] LOC_I, // Free space start
  output logic VALID_O, // Descriptor handed over
  output tcs_psp_t PSP_O // Descriptor words
);
  logic [2:0] wait_r;
  tcs_psp_t d;
  assign d = {{19'h0, 13'h1000 - {1'b0, LOC_I[11:0]}}, {2'b11, 2'b00, LOC_I}};
  // Released words show the inverse so stale data cannot pass
  assign PSP_O = VALID_O ? d : ~d;
  always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      wait_r <= 3'h0;
      VALID_O <= 1'b0;
    end else begin
      VALID_O <= wait_r == 3'h1;
      wait_r <= GO_I ? {1'b0, LAT_I} + 3'h1 : wait_r - {2'h0, wait_r != 3'h0};
    end
  end
endmodule

/* File: tb/tb.sv */
`timescale 1ns/100ps
module tb
  import tcs_pkg::*;
;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  tcs_axi_m2s_t m = '0;
  tcs_axi_s2m_t so, s;
  tcs_tx_evt_t evt = '0, base, e;
  logic go = 1'b0, ind_wr = 1'b0;
  logic [1:0] lat = 2'h0;
  logic [LOC_W-1:0] space_location = '0, ptr, limit;
  logic psp_valid, cnf_valid, tx_abort, req_abort, tok_rel, space_end, irq;
  logic [3:0] cnf_rs;
  tcs_psp_t pool_space_pointer;
  int mismatches = 0, n_compared = 0, k;
  logic [3:0] codes [12] = '{4'hb, 4'hb, 4'hb, 4'hb, 4'hb, 4'hc, 4'hf, 4'hf, 4'h8, 4'h9,
    4'hd, 4'h6};
  always #5 clock = ~clock;
  // Outputs move only at rising edges, so this copy is what each edge samples
  always @(negedge clock) s <= so;
  tcs_core i_tcs_core(.CLOCK_I(clock), .RST_B_I(rst_b), .AXI_I(m), .AXI_O(so), .EVT_I(evt),
    .PSP_VALID_I(psp_valid), .PSP_I(pool_space_pointer), .IND_WR_I(ind_wr), .CNF_VALID_O(cnf_valid),
    .CNF_RS_O(cnf_rs), .TX_ABORT_O(tx_abort), .REQ_ABORT_O(req_abort),
    .TOKEN_RELEASE_O(tok_rel), .IND_PTR_O(ptr), .IND_LIMIT_O(limit),
    .IND_SPACE_END_O(space_end), .IRQ_O(irq));
  tcs_host_mem i_tcs_host_mem(.CLOCK_I(clock), .RST_B_I(rst_b), .GO_I(go), .LAT_I(lat),
    .LOC_I(space_location), .VALID_O(psp_valid), .PSP_O(pool_space_pointer));
  task automatic chk(string n, logic [31:0] seen, logic [31:0] ex);
    n_compared++;
    if (seen !== ex) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, ex, seen);
    end
  endtask
  task automatic conclude;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d, logic [1:0] r = RESP_OKAY);
    @(posedge clock);
    m.awvalid <= 1'b1;
    m.wvalid <= 1'b1;
    m.awaddr <= a;
    m.wdata <= d;
    m.bready <= 1'b1;
    do begin
      @(posedge clock);
      if (s.awready) m.awvalid <= 1'b0;
      if (s.wready) m.wvalid <= 1'b0;
    end while (!s.bvalid);
    m.bready <= 1'b0;
    chk("bresp", s.bresp, r);
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] x, logic [1:0] r = RESP_OKAY);
    @(posedge clock);
    m.arvalid <= 1'b1;
    m.araddr <= a;
    m.rready <= 1'b1;
    do begin
      @(posedge clock);
      if (s.arready) m.arvalid <= 1'b0;
    end while (!s.rvalid);
    m.rready <= 1'b0;
    chk("rdata", s.rdata, x);
    chk("rresp", s.rresp, r);
  endtask
  task automatic ev(tcs_tx_evt_t x);
    @(posedge clock);
    evt <= x;
    @(posedge clock);
    evt <= base;
    #1;
  endtask
  task automatic start(logic [1:0] c, logic th);
    e = base;
    e.req_start = 1'b1;
    e.req_class = c;
    e.tht_en = th;
    ev(e);
    e = base;
  endtask
  task automatic confirmation_descriptor(logic [3:0] c);
    chk("cnf_valid", cnf_valid, 1);
    chk("cnf_rs", cnf_rs, c);
    chk("tx_abort", tx_abort, c == 4'hb);
    chk("req_abort", req_abort, c != 4'h6);
  endtask
  initial begin
    base = '0;
    base.ring_op = 1'b1;
    m.wstrb = 4'hf;
    repeat (10) @(posedge clock);
    rst_b <= 1'b1;
    rd(ADDR_CTRL, 32'h1);
    rd(ADDR_IRQ_MASK, 32'h0);
    rd(8'h18, 32'h0, RESP_SLVERR);
    wr(8'h18, 32'h0, RESP_SLVERR);
    start(2'h0, 1'b0);
    e.cnf_space_low = 1'b1;
    ev(e);
    confirmation_descriptor(4'h9);
    chk("irq_masked", irq, 0);
    rd(ADDR_IRQ_STAT, 32'h3);
    wr(ADDR_IRQ_MASK, 32'hf);
    #1 chk("irq_on", irq, 1);
    wr(ADDR_IRQ_STAT, 32'hf);
    #1 chk("irq_off", irq, 0);
    for (k = 0; k < 12; k++) begin
      start(2'h0, 1'b0);
      case (k)
        0: e.parity_err = 1'b1;
        1: e.fc_fail = 1'b1;
        2: e.mac_frame_in_data = 1'b1;
        3: e.other_beacon_in_beacon = 1'b1;
        4: e.claim_lost_in_claim = 1'b1;
        5: e.trt_expired = 1'b1;
        6: e.tx_internal_err = 1'b1;
        7: e.bus_err = 1'b1;
        8: e.underrun = 1'b1;
        9: e.cnf_space_low = 1'b1;
        10: e.illegal_state = 1'b1;
        default: e.req_end = 1'b1;
      endcase
      ev(e);
      confirmation_descriptor(codes[k]);
    end
    start(2'h3, 1'b0);
    confirmation_descriptor(4'ha);
    base.ring_op = 1'b0;
    start(2'h1, 1'b0);
    confirmation_descriptor(4'ha);
    start(2'h3, 1'b0);
    e.req_end = 1'b1;
    ev(e);
    confirmation_descriptor(4'h6);
    base.ring_op = 1'b1;
    start(2'h0, 1'b0);
    wr(ADDR_CTRL, 32'h3);
    rd(ADDR_STAT, 32'hd0);
    start(2'h0, 1'b0);
    wr(ADDR_CTRL, 32'h0);
    rd(ADDR_STAT, 32'h90);
    wr(ADDR_CTRL, 32'h1);
    start(2'h0, 1'b0);
    e.output_data_unit_descriptor_valid = 1'b1;
    e.output_data_unit_descriptor_tag = 2'b10;
    ev(e);
    ev(e);
    confirmation_descriptor(4'he);
    start(2'h0, 1'b1);
    e.tht_expired = 1'b1;
    e.trt_expired = 1'b1;
    ev(e);
    e = base;
    e.frame_end = 1'b1;
    ev(e);
    confirmation_descriptor(4'h6);
    chk("token_release", tok_rel, 1);
    for (k = 0; k < 2; k++) begin
      @(posedge clock);
      space_location <= k ? 28'h0001ff0 : 28'h0abc000;
      lat <= k ? 2'h0 : 2'h2;
      go <= 1'b1;
      @(posedge clock);
      go <= 1'b0;
      while (!psp_valid) @(negedge clock);
      @(posedge clock);
      #1 chk("ptr", ptr, space_location);
      chk("limit", limit, {space_location[27:12] + 16'h1, 12'h0});
    end
    @(posedge clock);
    ind_wr <= 1'b1;
    // The fourth write reaches the limit and the fifth must not move the pointer
    repeat (5) @(posedge clock);
    ind_wr <= 1'b0;
    #1 chk("space_end", space_end, 1);
    chk("ptr_end", ptr, 28'h0002000);
    rd(ADDR_IRQ_STAT, 32'hf);
    conclude;
  end
  initial begin
    #100us;
    mismatches++;
    conclude;
  end
endmodule
bind tcs_core tcs_monitor i_tcs_monitor(.CLOCK_I(CLOCK_I), .RST_B_I(RST_B_I),
  .PSP_VALID_I(PSP_VALID_I), .PSP_I(PSP_I), .IND_WR_I(IND_WR_I), .CNF_VALID_O(CNF_VALID_O),
  .CNF_RS_O(CNF_RS_O), .TX_ABORT_O(TX_ABORT_O), .REQ_ABORT_O(REQ_ABORT_O),
  .TOKEN_RELEASE_O(TOKEN_RELEASE_O), .IND_PTR_O(IND_PTR_O), .IND_LIMIT_O(IND_LIMIT_O),
  .IND_SPACE_END_O(IND_SPACE_END_O));
